// file: tb/ata_cmd_core_chk.sv
// Purpose: port checker for the ata command engine
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every ata_cmd_core instance
`timescale 1ns/100ps
`default_nettype none
module ata_cmd_core_chk
	import ata_cmd_pkg::*;
(
	// clock and reset
	input wire logic                   i_core_clk,
	input wire logic                   i_rst,
	// watched ports
	input wire ata_cmd_pkg::axil_req_s i_axil,
	input wire ata_cmd_pkg::axil_rsp_s o_axil,
	input wire logic                   o_dmarq,
	input wire logic                   i_media_ready,
	input wire logic                   i_media_err,
	input wire logic                   o_standby,
	input wire logic                   o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic wtake;
	logic rtake;
	assign wtake = i_axil.awvalid && i_axil.wvalid && !o_axil.bvalid;
	assign rtake = i_axil.arvalid && !o_axil.rvalid;
	wr_answer_a: assert property (wtake |=> o_axil.bvalid) else $error("write answer late");
	rd_answer_a: assert property (rtake |=> o_axil.rvalid) else $error("read answer late");
	bresp_hold_a: assert property (o_axil.bvalid && !i_axil.bready |=> o_axil.bvalid && $stable(o_axil.bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (o_axil.rvalid && !i_axil.rready |=> o_axil.rvalid && $stable(o_axil.rdata))
		else $error("read answer dropped");
	pair_take_a: assert property (o_axil.awready && i_axil.awvalid |-> i_axil.wvalid) else $error("address taken alone");
	ident_bit_a: assert property (rtake && i_axil.araddr == OFS_IDENT82 |=> o_axil.rdata[0])
		else $error("feature bit clear");
	stall_drop_a: assert property (!i_media_ready |=> !o_dmarq) else $error("request kept while stalled");
	err_stop_a: assert property (i_media_err |=> !o_dmarq) else $error("request kept after error");
	wake_up_a: assert property (o_standby && wtake && i_axil.awaddr == OFS_COMMAND
		&& i_axil.wdata[7:0] == OP_TRANSLATE |=> ##[0:2] !o_standby) else $error("still in standby");
	cover property ($rose(o_dmarq));
	cover property ($rose(o_standby));
	cover property ($rose(o_irq));
endmodule // ata_cmd_core_chk
bind ata_cmd_core ata_cmd_core_chk chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_axil(i_axil), .o_axil(o_axil),
	.o_dmarq(o_dmarq), .i_media_ready(i_media_ready), .i_media_err(i_media_err), .o_standby(o_standby), .o_irq(o_irq));
`default_nettype wire

// file: tb/ata_host_model.sv
// Purpose: host side of the dma write link
// Assumes: one word per strobe, low and high phases of three clocks or more
// Notes:   i_slow stretches the gap between words
`timescale 1ns/100ps
`default_nettype none
module ata_host_model (
	// clock and control
	input  wire logic        i_core_clk,
	input  wire logic        i_dmarq,
	input  wire logic        i_slow,
	// dma pins
	output logic             o_dmack_n,
	output logic             o_iowr_n,
	output logic [15:0]      o_dd,
	output int               o_words
);
	initial begin
		o_dmack_n = 1'b1;
		o_iowr_n  = 1'b1;
		o_dd      = 16'h0000;
		o_words   = 0;
		forever begin
			@(posedge i_core_clk);
			if (i_dmarq === 1'b1) begin
				o_dmack_n <= 1'b0;
				o_dd      <= 16'(o_words * 7 + 1);
				o_iowr_n  <= 1'b0;
				repeat (3) @(posedge i_core_clk);
				o_iowr_n  <= 1'b1;
				o_words   <= o_words + 1;
				// data held well past the trailing edge so the synchroniser sees it
				repeat (i_slow ? 12 : 5) @(posedge i_core_clk);
			end else begin
				o_dmack_n <= 1'b1;
				o_dd      <= ~o_dd;
			end
		end
	end
endmodule // ata_host_model
`default_nettype wire

// file: tb/ata_power_buffer_dma_write_cmds_bench.sv
// Purpose: self-checking bench for the ata command engine
// Assumes: axi4-lite master tasks here, host model on the dma pins
// Notes:   random task-file values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module ata_power_buffer_dma_write_cmds_bench;
	import ata_cmd_pkg::*;
	logic        clk, rst, dmack_n, iowr_n, slow, mrdy, merr, irq, irq_q, stby, dmarq;
	logic [15:0] dd, brd;
	logic [7:0]  braddr;
	logic [31:0] d;
	logic [1:0]  r;
	logic [27:0] a0, a1;
	logic [15:0] mem [256];
	logic [7:0]  ops [6] = '{OP_SLEEP_A, OP_SLEEP_B, OP_STBY_A, OP_STBY_B, OP_STBYI_A, OP_STBYI_B};
	axil_req_s   req;
	axil_rsp_s   rsp;
	int          error_cnt, tests_run, words, w0, n, rises;
	ata_cmd_core uut (.i_core_clk(clk), .i_rst(rst), .i_axil(req), .o_axil(rsp), .i_dmack_n(dmack_n),
		.i_iowr_n(iowr_n), .i_dd(dd), .o_dmarq(dmarq), .i_media_ready(mrdy), .i_media_err(merr),
		.i_buf_raddr(braddr), .o_buf_rdata(brd), .o_standby(stby), .o_irq(irq));
	ata_host_model host (.i_core_clk(clk), .i_dmarq(dmarq), .i_slow(slow), .o_dmack_n(dmack_n),
		.o_iowr_n(iowr_n), .o_dd(dd), .o_words(words));
	task automatic final_report();
		$display("tests %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		final_report();
	endtask
	// ready and valid are sampled mid-cycle, where they equal the next edge's value
	task automatic hs(input int k);
		n = 0;
		@(negedge clk);
		while ((k == 0 ? rsp.awready : k == 1 ? rsp.bvalid : k == 2 ? rsp.arready : rsp.rvalid) !== 1'b1) begin
			if (++n > 50) tmo();
			@(negedge clk);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req.awaddr <= a; req.wdata <= v; req.wstrb <= 4'hF; req.awvalid <= 1'b1; req.wvalid <= 1'b1;
		hs(0);
		@(posedge clk);
		req.awvalid <= 1'b0; req.wvalid <= 1'b0; req.bready <= 1'b1;
		hs(1);
		@(posedge clk);
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
		hs(2);
		@(posedge clk);
		req.arvalid <= 1'b0;
		hs(3);
		d = rsp.rdata; r = rsp.rresp;
		@(posedge clk);
		req.rready <= 1'b0;
	endtask
	task automatic wirq();
		n = 0;
		while (irq !== 1'b1) begin
			if (++n > 20000) tmo();
			@(posedge clk);
		end
	endtask
	task automatic dma(input logic [7:0] c);
		a0 = 28'($urandom); a0[7:0] = 8'hFF; // carry into cylinder low
		wr(OFS_SEC_NUM, {24'h0, a0[7:0]}); wr(OFS_CYL_LOW, {24'h0, a0[15:8]}); wr(OFS_CYL_HIGH, {24'h0, a0[23:16]});
		wr(OFS_DEV_HEAD, {24'h0, 4'hE, a0[27:24]}); wr(OFS_SEC_COUNT, {24'h0, c});
		w0 = words; wr(OFS_COMMAND, {24'h0, OP_WR_DMA});
		rd(OFS_STATUS); `CHK("dma drq", 2'b01, {d[STAT_BSY], d[STAT_DRQ]})
	endtask
	task automatic rd_lba();
		rd(OFS_SEC_NUM); a1[7:0] = d[7:0]; rd(OFS_CYL_LOW); a1[15:8] = d[7:0];
		rd(OFS_CYL_HIGH); a1[23:16] = d[7:0]; rd(OFS_DEV_HEAD); a1[27:24] = d[3:0];
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		irq_q <= irq;
		if (irq === 1'b1 && irq_q === 1'b0) rises++;
	end
	initial begin
		req = '0; rst = 1'b1; slow = 1'b0; mrdy = 1'b1; merr = 1'b0; braddr = 8'h00;
		error_cnt = 0; tests_run = 0; rises = 0;
		void'($urandom(32'h18A4536A));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_INT_MASK); `CHK("mask rst", 32'h0, d)
		rd(OFS_IDENT82); `CHK("ident", 1'b1, d[0])
		rd(8'h3C); `CHK("unmapped", RESP_DECERR, r)
		@(negedge clk); `CHK("rst pins", 3'b000, {stby, irq, dmarq})
		$display("test reset done");
		wr(OFS_INT_MASK, 32'h3);
		foreach (ops[i]) begin
			wr(OFS_COMMAND, {24'h0, ops[i]});
			rd(OFS_STATUS); @(negedge clk);
			`CHK("standby", 2'b10, {stby, d[STAT_BSY]})
			`CHK("power irq", 1'b1, irq)
			wr(OFS_INT_STAT, 32'h1); @(negedge clk); `CHK("irq clear", 1'b0, irq)
		end
		$display("test power done");
		wr(OFS_INT_MASK, 32'h0); wr(OFS_SEC_COUNT, 32'($urandom_range(1, 255)));
		wr(OFS_COMMAND, {24'h0, OP_TRANSLATE}); rd(OFS_SEC_COUNT); @(negedge clk);
		`CHK("wake", 1'b0, stby)
		`CHK("xlat count", 8'h00, d[7:0])
		`CHK("masked irq", 1'b0, irq)
		wr(OFS_INT_MASK, 32'h3); @(negedge clk); `CHK("unmasked irq", 1'b1, irq)
		wr(OFS_INT_STAT, 32'h3);
		$display("test translate done");
		wr(OFS_COMMAND, {24'h0, OP_WR_BUFFER});
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'($urandom);
			wr(OFS_DATA, {16'h0, mem[i]});
			if (i == 254) begin
				@(negedge clk); `CHK("early done", 1'b0, irq)
			end
		end
		@(negedge clk); `CHK("buffer done", 1'b1, irq)
		for (int i = 0; i < 256; i++) begin
			@(posedge clk); braddr <= 8'(i);
			@(posedge clk); @(negedge clk); `CHK("buffer", mem[i], brd)
		end
		wr(OFS_INT_STAT, 32'h3);
		$display("test buffer done");
		wr(OFS_CONFIG, 32'h1); wr(OFS_COMMAND, {24'h0, OP_WR_DMA}); rd(OFS_ERROR); @(negedge clk);
		`CHK("eight bit", 2'b10, {d[ERR_ABRT], dmarq})
		wr(OFS_CONFIG, 32'h0); wr(OFS_INT_STAT, 32'h3);
		$display("test abort done");
		slow = 1'b1; dma(8'h02); w0 = w0 + 0; rises = 0;
		n = 0;
		while (words - w0 < 20) begin if (++n > 5000) tmo(); @(posedge clk); end
		mrdy <= 1'b0; repeat (10) @(posedge clk); @(negedge clk); `CHK("stall", 1'b0, dmarq)
		@(posedge clk); mrdy <= 1'b1;
		wirq(); repeat (50) @(posedge clk); @(negedge clk);
		`CHK("words", 512, words - w0)
		`CHK("one irq", 1, rises)
		// the host numbers its words from zero and sends word n as n*7+1; the buffer keeps the last sector
		for (int i = 0; i < 256; i++) begin
			@(posedge clk); braddr <= 8'(i);
			@(posedge clk); @(negedge clk); `CHK("dma data", 16'((w0 + 256 + i) * 7 + 1), brd)
		end
		rd_lba(); `CHK("last lba", a0 + 28'h1, a1)
		wr(OFS_INT_STAT, 32'h3);
		$display("test dma done");
		slow = 1'b0; dma(8'h00);
		n = 0;
		while (words - w0 < 300) begin if (++n > 5000) tmo(); @(posedge clk); end
		merr <= 1'b1; wirq(); @(posedge clk); merr <= 1'b0;
		rd(OFS_INT_STAT); `CHK("err irq", 1'b1, d[INT_ERROR])
		rd_lba(); `CHK("fail lba", a0 + 28'h1, a1)
		rd(OFS_SEC_COUNT); `CHK("remaining", 8'hFF, d[7:0])
		$display("test dma error done");
		final_report();
	end
endmodule // ata_power_buffer_dma_write_cmds_bench
`default_nettype wire

// file: verilog/ata_cmd_core.sv
// Purpose: device-side task-file command engine with dma write and sector buffer
// Assumes: single clock, synchronous active-high reset, dma pins asynchronous
// Notes:   registers over axi4-lite; one write and one read outstanding
// Functional notes
// - sleep opcodes: busy, enter standby, drop busy, interrupt at once
// - standby opcodes behave exactly like sleep
// - standby-immediate opcodes behave exactly like sleep
// - any new command takes the device out of standby
// - identify word 82 bit 0 reports self-monitoring support
// - translate sector does nothing and returns sector count zero
// - write buffer takes exactly 512 bytes by pio into the sector buffer
// - dma write moves 1 to 256 sectors, zero meaning 256
// - dma write starts at the loaded task-file address
// - dma write sets busy first, then drq and clears busy
// - dma request held while more words can be accepted
// - one interrupt only at end of transfer or on error
// - on success address registers hold the last sector written
// - on error stop at failing sector and report its address
// - dma write with 8-bit mode enabled aborts
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ata_cmd_core
	import ata_cmd_pkg::*;
#(
	parameter int BUF_WORDS = 256
) (
	// clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	// register bus
	input  wire ata_cmd_pkg::axil_req_s i_axil,
	output      ata_cmd_pkg::axil_rsp_s o_axil,
	// dma pins
	input  wire logic                   i_dmack_n,
	input  wire logic                   i_iowr_n,
	input  wire logic [15:0]            i_dd,
	output      logic                   o_dmarq,
	// media side
	input  wire logic                   i_media_ready,
	input  wire logic                   i_media_err,
	input  wire logic [7:0]             i_buf_raddr,
	output      logic [15:0]            o_buf_rdata,
	// status
	output      logic                   o_standby,
	output      logic                   o_irq
);
	import ata_cmd_pkg::*;

	if (BUF_WORDS != 256) begin : g_bad_depth
		$error("BUF_WORDS must be 256, one sector of 16-bit words");
	end

	typedef struct packed {
		cmd_state_e  st;
		logic [7:0]  feature;
		logic [7:0]  sec_count;
		logic [7:0]  sec_num;
		logic [7:0]  cyl_low;
		logic [7:0]  cyl_high;
		logic [7:0]  dev_head;
		logic        bsy;
		logic        drq;
		logic        err;
		logic        abrt;
		logic        standby;
		logic        eight_bit;
		logic [1:0]  int_stat;
		logic [1:0]  int_mask;
		logic [7:0]  word;
		logic [8:0]  remain;
		logic        dmarq;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        dmack_s1;
		logic        dmack_s2;
		logic        iowr_s1;
		logic        iowr_s2;
		logic        iowr_prev;
		logic [15:0] dd_s1;
		logic [15:0] dd_s2;
		logic [15:0] buf_rdata;
	} core_state_s;

	core_state_s       cur;
	core_state_s       next_cur;
	logic [15:0]       sector_buf [0:255];
	logic              mem_we;
	logic [7:0]        mem_addr;
	logic [15:0]       mem_wdata;

	// handshake outputs stay combinational to keep one-cycle acceptance
	logic wr_take;
	logic rd_take;
	assign wr_take = i_axil.awvalid && i_axil.wvalid && !cur.bvalid;
	assign rd_take = i_axil.arvalid && !cur.rvalid;

	always_comb begin
		o_axil.awready = wr_take;
		o_axil.wready  = wr_take;
		o_axil.bvalid  = cur.bvalid;
		o_axil.bresp   = cur.bresp;
		o_axil.arready = rd_take;
		o_axil.rvalid  = cur.rvalid;
		o_axil.rdata   = cur.rdata;
		o_axil.rresp   = cur.rresp;
	end

	assign o_dmarq     = cur.dmarq;
	assign o_buf_rdata = cur.buf_rdata;
	assign o_standby   = cur.standby;
	assign o_irq       = |(cur.int_stat & cur.int_mask);

	always_comb begin
		logic [27:0] lba;
		logic        word_in;
		logic        last_word;
		logic [1:0]  ev;
		logic [15:0] status;
		next_cur  = cur;
		lba       = {cur.dev_head[3:0], cur.cyl_high, cur.cyl_low, cur.sec_num};
		word_in   = 1'b0;
		last_word = (cur.word == SECTOR_WORDS_M1);
		ev        = 2'b00;
		mem_we    = 1'b0;
		mem_addr  = cur.word;
		mem_wdata = cur.dd_s2;
		status    = 16'h0000;

		// pins cross in through two flops; logic looks at the second, plus a third strobe flop for the edge
		next_cur.dmack_s1  = i_dmack_n;
		next_cur.dmack_s2  = cur.dmack_s1;
		next_cur.iowr_s1   = i_iowr_n;
		next_cur.iowr_s2   = cur.iowr_s1;
		next_cur.iowr_prev = cur.iowr_s2;
		next_cur.dd_s1     = i_dd;
		next_cur.dd_s2     = cur.dd_s1;
		next_cur.buf_rdata = sector_buf[i_buf_raddr];

		// word latched on the trailing edge of the write strobe under acknowledge
		word_in = !cur.dmack_s2 && cur.iowr_s2 && !cur.iowr_prev;

		// axi read
		if (cur.rvalid && i_axil.rready) begin
			next_cur.rvalid = 1'b0;
		end
		if (rd_take) begin
			status[STAT_BSY]     = cur.bsy;
			status[STAT_DRDY]    = !cur.bsy;
			status[STAT_DRQ]     = cur.drq;
			status[STAT_ERR]     = cur.err;
			status[STAT_STANDBY] = cur.standby;
			next_cur.rvalid = 1'b1;
			next_cur.rresp  = RESP_OKAY;
			next_cur.rdata  = 32'h0000_0000;
			case (i_axil.araddr)
				OFS_FEATURE:   next_cur.rdata[7:0]  = cur.feature;
				OFS_SEC_COUNT: next_cur.rdata[7:0]  = cur.sec_count;
				OFS_SEC_NUM:   next_cur.rdata[7:0]  = cur.sec_num;
				OFS_CYL_LOW:   next_cur.rdata[7:0]  = cur.cyl_low;
				OFS_CYL_HIGH:  next_cur.rdata[7:0]  = cur.cyl_high;
				OFS_DEV_HEAD:  next_cur.rdata[7:0]  = cur.dev_head;
				OFS_COMMAND:   next_cur.rdata[15:0] = status;
				OFS_STATUS:    next_cur.rdata[15:0] = status;
				OFS_ERROR:     next_cur.rdata[ERR_ABRT] = cur.abrt;
				OFS_DATA:      next_cur.rdata = 32'h0000_0000;
				OFS_CONFIG:    next_cur.rdata[0]    = cur.eight_bit;
				OFS_IDENT82:   next_cur.rdata[15:0] = IDENT82_VAL;
				OFS_INT_STAT:  next_cur.rdata[1:0]  = cur.int_stat;
				OFS_INT_MASK:  next_cur.rdata[1:0]  = cur.int_mask;
				default:       next_cur.rresp = RESP_DECERR;
			endcase
		end

		// axi write
		if (cur.bvalid && i_axil.bready) begin
			next_cur.bvalid = 1'b0;
		end
		if (wr_take) begin
			next_cur.bvalid = 1'b1;
			next_cur.bresp  = RESP_OKAY;
			case (i_axil.awaddr)
				OFS_FEATURE, OFS_SEC_COUNT, OFS_SEC_NUM,
				OFS_CYL_LOW, OFS_CYL_HIGH, OFS_DEV_HEAD: begin
					// task file is frozen while a command owns it
					if (i_axil.wstrb[0] && cur.st == ST_IDLE) begin
						case (i_axil.awaddr)
							OFS_FEATURE:   next_cur.feature   = i_axil.wdata[7:0];
							OFS_SEC_COUNT: next_cur.sec_count = i_axil.wdata[7:0];
							OFS_SEC_NUM:   next_cur.sec_num   = i_axil.wdata[7:0];
							OFS_CYL_LOW:   next_cur.cyl_low   = i_axil.wdata[7:0];
							OFS_CYL_HIGH:  next_cur.cyl_high  = i_axil.wdata[7:0];
							default:       next_cur.dev_head  = i_axil.wdata[7:0];
						endcase
					end
				end
				OFS_COMMAND: begin
					if (i_axil.wstrb[0] && cur.st == ST_IDLE) begin
						next_cur.standby = 1'b0;
						next_cur.bsy     = 1'b1;
						next_cur.err     = 1'b0;
						next_cur.abrt    = 1'b0;
						next_cur.word    = 8'h00;
						case (i_axil.wdata[7:0])
							OP_SLEEP_A, OP_SLEEP_B: next_cur.st = ST_POWER;
							OP_STBY_A, OP_STBY_B:   next_cur.st = ST_POWER;
							OP_STBYI_A, OP_STBYI_B: next_cur.st = ST_POWER;
							OP_TRANSLATE: begin
								next_cur.sec_count = 8'h00;
								next_cur.st        = ST_DONE;
							end
							OP_WR_BUFFER: begin
								next_cur.st  = ST_BUF_WR;
								next_cur.bsy = 1'b0;
								next_cur.drq = 1'b1;
							end
							OP_WR_DMA: begin
								if (cur.eight_bit) begin
									next_cur.err  = 1'b1;
									next_cur.abrt = 1'b1;
									next_cur.st   = ST_DONE;
								end else begin
									// zero in the count register asks for the full 256
									next_cur.remain = (cur.sec_count == 8'h00) ? MAX_SECTORS
										: {1'b0, cur.sec_count};
									next_cur.st = ST_DMA_PRE;
								end
							end
							default: begin
								next_cur.err  = 1'b1;
								next_cur.abrt = 1'b1;
								next_cur.st   = ST_DONE;
							end
						endcase
					end
				end
				OFS_DATA: begin
					if (cur.st == ST_BUF_WR && i_axil.wstrb[1:0] == 2'b11) begin
						mem_we    = 1'b1;
						mem_wdata = i_axil.wdata[15:0];
						next_cur.word = cur.word + 8'h01;
						if (last_word) begin
							next_cur.drq = 1'b0;
							next_cur.st  = ST_DONE;
						end
					end
				end
				OFS_CONFIG:   next_cur.eight_bit = i_axil.wdata[0];
				OFS_INT_STAT: next_cur.int_stat  = cur.int_stat & ~i_axil.wdata[1:0];
				OFS_INT_MASK: next_cur.int_mask  = i_axil.wdata[1:0];
				OFS_STATUS, OFS_ERROR, OFS_IDENT82: ;
				default: next_cur.bresp = RESP_DECERR;
			endcase
		end

		// command engine
		case (cur.st)
			ST_IDLE: ;
			ST_POWER: begin
				next_cur.standby = 1'b1;
				next_cur.st      = ST_DONE;
			end
			ST_BUF_WR: ;
			ST_DMA_PRE: begin
				// buffer is free at once, so drq replaces busy one cycle later
				next_cur.bsy = 1'b0;
				next_cur.drq = 1'b1;
				next_cur.st  = ST_DMA;
			end
			ST_DMA: begin
				if (i_media_err) begin
					// address fields already point at the failing sector
					next_cur.err       = 1'b1;
					next_cur.abrt      = 1'b0;
					next_cur.drq       = 1'b0;
					next_cur.sec_count = cur.remain[7:0];
					next_cur.st        = ST_DONE;
				end else if (word_in) begin
					mem_we        = 1'b1;
					mem_addr      = cur.word;
					mem_wdata     = cur.dd_s2;
					next_cur.word = cur.word + 8'h01;
					if (last_word) begin
						if (cur.remain == 9'h001) begin
							// leave the address on the last sector written
							next_cur.drq = 1'b0;
							next_cur.st  = ST_DONE;
						end else begin
							next_cur.remain   = cur.remain - 9'h001;
							lba               = lba + 28'h000_0001;
							next_cur.sec_num  = lba[7:0];
							next_cur.cyl_low  = lba[15:8];
							next_cur.cyl_high = lba[23:16];
							next_cur.dev_head = {cur.dev_head[7:4], lba[27:24]};
						end
					end
				end
			end
			ST_DONE: begin
				next_cur.bsy = 1'b0;
				next_cur.drq = 1'b0;
				ev[INT_DONE]  = 1'b1;
				ev[INT_ERROR] = cur.err;
				next_cur.st   = ST_IDLE;
			end
			default: next_cur.st = ST_IDLE;
		endcase

		// request stays up only while a whole word more can be taken
		next_cur.dmarq = (next_cur.st == ST_DMA) && i_media_ready && !i_media_err;

		// a new event beats a simultaneous clear
		next_cur.int_stat = next_cur.int_stat | ev;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cur           <= '0;
			cur.st        <= ST_IDLE;
			cur.iowr_s1   <= 1'b1;
			cur.iowr_s2   <= 1'b1;
			cur.iowr_prev <= 1'b1;
			cur.dmack_s1  <= 1'b1;
			cur.dmack_s2  <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// sector buffer has no reset; contents are defined by the writes
	always_ff @(posedge i_core_clk) begin
		if (mem_we) begin
			sector_buf[mem_addr] <= mem_wdata;
		end
	end
endmodule // ata_cmd_core
`default_nettype wire

// file: verilog/ata_cmd_pkg.sv
// Purpose: shared constants and carriers for the ata command block
// Assumes: axi4-lite, 32-bit data, byte addresses
// Notes:   opcodes and address fields follow the task-file layout
package ata_cmd_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_FEATURE   = 8'h00;
	localparam logic [7:0] OFS_SEC_COUNT = 8'h04;
	localparam logic [7:0] OFS_SEC_NUM   = 8'h08;
	localparam logic [7:0] OFS_CYL_LOW   = 8'h0C;
	localparam logic [7:0] OFS_CYL_HIGH  = 8'h10;
	localparam logic [7:0] OFS_DEV_HEAD  = 8'h14;
	localparam logic [7:0] OFS_COMMAND   = 8'h18;
	localparam logic [7:0] OFS_STATUS    = 8'h1C;
	localparam logic [7:0] OFS_ERROR     = 8'h20;
	localparam logic [7:0] OFS_DATA      = 8'h24;
	localparam logic [7:0] OFS_CONFIG    = 8'h28;
	localparam logic [7:0] OFS_IDENT82   = 8'h2C;
	localparam logic [7:0] OFS_INT_STAT  = 8'h30;
	localparam logic [7:0] OFS_INT_MASK  = 8'h34;
	// opcodes
	localparam logic [7:0] OP_SLEEP_A    = 8'h99;
	localparam logic [7:0] OP_SLEEP_B    = 8'hE6;
	localparam logic [7:0] OP_STBY_A     = 8'h96;
	localparam logic [7:0] OP_STBY_B     = 8'hE2;
	localparam logic [7:0] OP_STBYI_A    = 8'h94;
	localparam logic [7:0] OP_STBYI_B    = 8'hE0;
	localparam logic [7:0] OP_TRANSLATE  = 8'h87;
	localparam logic [7:0] OP_WR_BUFFER  = 8'hE8;
	localparam logic [7:0] OP_WR_DMA     = 8'hCA;
	// field positions and values
	localparam int         STAT_BSY      = 7;
	localparam int         STAT_DRDY     = 6;
	localparam int         STAT_DRQ      = 3;
	localparam int         STAT_ERR      = 0;
	localparam int         STAT_STANDBY  = 8;
	localparam int         ERR_ABRT      = 2;
	localparam int         DH_LBA        = 6;
	localparam int         INT_DONE      = 0;
	localparam int         INT_ERROR     = 1;
	localparam logic [15:0] IDENT82_VAL  = 16'h0001;
	localparam logic [7:0] SECTOR_WORDS_M1 = 8'hFF;
	localparam logic [8:0] MAX_SECTORS   = 9'h100;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_DECERR   = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_POWER   = 3'b001,
		ST_BUF_WR  = 3'b010,
		ST_DMA_PRE = 3'b011,
		ST_DMA     = 3'b100,
		ST_DONE    = 3'b101
	} cmd_state_e;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_s;
endpackage
